/* File: common/radio_cfg_regs.svh */
`ifndef RADIO_CFG_REGS_SVH
`define RADIO_CFG_REGS_SVH
// ********************************************************************
// register byte addresses
// ********************************************************************
`define ADDR_BASE_WORD_ZERO   12'h51C
`define ADDR_BASE_WORD_ONE    12'h520
`define ADDR_PREFIX_LOW       12'h524
`define ADDR_PREFIX_HIGH      12'h528
`define ADDR_TX_SELECT        12'h52C
`define ADDR_RX_ENABLES       12'h530
`define ADDR_CRC_CONFIG       12'h534
`define ADDR_CRC_POLY         12'h538
`define ADDR_CRC_SEED         12'h53C
`define ADDR_BASE_BYTE_COUNT  12'h518
// ********************************************************************
// field layout and reset values
// ********************************************************************
`define RST_WORD              32'h0000_0000
`define CRC_LEN_LSB           0
`define CRC_LEN_MSB           1
`define CRC_SKIP_BIT          8
`define TX_SEL_MSB            2
`define RX_EN_MSB             7
`define BASE_CNT_LSB          16
`define BASE_CNT_MSB          18
`define BASE_CNT_RESET        3'h4
`define CRC_WIDTH             24
`define DATA_WIDTH            32
`define ADDR_WIDTH            12
`endif

/* File: common/radio_cfg_pkg.sv */
package radio_cfg_pkg;
    typedef logic [31:0] word_t;
    typedef logic [2:0]  lane_t;
    typedef logic [1:0]  crc_len_t;
    // serialiser states, gray from ST_IDLE to ST_DONE along the usual path
    typedef enum logic [2:0] {
        ST_IDLE = 3'h0,
        ST_ADDR = 3'h1,
        ST_BODY = 3'h3,
        ST_CRC  = 3'h2,
        ST_DONE = 3'h6
    } frame_state_t;
endpackage

/* File: src/crc_engine.sv */
`timescale 1ns/100ps
`include "radio_cfg_regs.svh"
// ********************************************************************
// bytewise crc shift register, up to 24 bits, msb first
// ********************************************************************
module crc_engine
    import radio_cfg_pkg::*;
(
    input  wire logic                      i_sys_clk,
    input  wire logic                      i_srst,
    input  wire logic                      i_ce,
    input  wire logic                      i_start,
    input  wire logic [`CRC_WIDTH-1:0]     i_seed,
    input  wire logic [`CRC_WIDTH-1:0]     i_poly,
    input  wire logic [1:0]                i_len,
    input  wire logic                      i_byte_valid,
    input  wire logic [7:0]                i_byte,
    output logic      [`CRC_WIDTH-1:0]     o_crc
);
    logic [`CRC_WIDTH-1:0] next_crc;
    logic [`CRC_WIDTH-1:0] poly_eff;
    logic [4:0]            top;
    // bit 0 of the polynomial is forced to one
    always_comb begin
        poly_eff = {i_poly[`CRC_WIDTH-1:1], 1'b1};
        top      = 5'(8 * i_len - 1);
        next_crc = o_crc;
        for (int b = 7; b >= 0; b--) begin
            if (next_crc[top] ^ i_byte[b]) begin
                next_crc = (next_crc << 1) ^ poly_eff;
            end else begin
                next_crc = next_crc << 1;
            end
        end
        for (int k = 0; k < `CRC_WIDTH; k++) begin
            if (k > int'(top)) begin
                next_crc[k] = 1'b0;
            end
        end
    end
    // seed on start, then one byte per valid while the crc length is not zero
    always_ff @(posedge i_sys_clk) begin
        if (i_srst) begin
            o_crc <= '0;
        end else if (i_ce) begin
            if (i_start) begin
                o_crc <= i_seed;
            end else if (i_byte_valid && i_len != 2'h0) begin
                o_crc <= next_crc;
            end
        end
    end
endmodule

/* File: src/radio_address_crc_config.sv */
`timescale 1ns/100ps
`include "radio_cfg_regs.svh"
// Summary of operation
// - prefix_low_group holds one-byte prefixes of logical addresses zero to three
// - prefix_high_group holds one-byte prefixes of logical addresses four to seven
// - transmit uses logical address chosen by tx_logical_select
// - rx_logical_enables bit i allows reception on logical address i
// - crc length zero: no crc appended, checked or computed
// - crc lengths one to three give one to three crc bytes
// - address skip zero: crc covers address field too
// - address skip one: crc starts at first byte after address
// - polynomial bit index equals term exponent
// - constant term always present, written bit zero ignored
// - crc register loads seed at start of each computation
// - on-air address is base bytes then one prefix byte
module radio_address_crc_config
    import radio_cfg_pkg::*;
(
    input  wire logic                    i_sys_clk,
    input  wire logic                    i_srst,
    input  wire logic                    i_ce,
    input  wire logic [`ADDR_WIDTH-1:0]  i_avs_address,
    input  wire logic                    i_avs_read,
    input  wire logic                    i_avs_write,
    input  wire logic [3:0]              i_avs_byteenable,
    input  wire logic [`DATA_WIDTH-1:0]  i_avs_writedata,
    output logic      [`DATA_WIDTH-1:0]  o_avs_readdata,
    output logic                         o_avs_waitrequest,
    input  wire logic                    i_tx_start,
    input  wire logic                    i_tx_ready,
    input  wire logic                    i_body_valid,
    input  wire logic [7:0]              i_body_byte,
    input  wire logic                    i_body_last,
    output logic                         o_body_ready,
    output logic                         o_tx_valid,
    output logic      [7:0]              o_tx_byte,
    output logic                         o_tx_last,
    input  wire logic [2:0]              i_rx_logical,
    output logic                         o_rx_allowed,
    output logic                         o_busy
);
    import radio_cfg_pkg::*;
    // ********************************************************************
    // register file
    // ********************************************************************
    word_t base_word_zero;
    word_t base_word_one;
    word_t prefix_low_group;
    word_t prefix_high_group;
    word_t tx_logical_select;
    word_t rx_logical_enables;
    word_t crc_config;
    word_t crc_polynomial;
    word_t crc_seed;
    word_t base_byte_count;
    logic  ack;
    logic  wr_hit;
    // merge write data under byte enables
    function automatic word_t merge(input word_t old, input word_t nw, input logic [3:0] be);
        word_t r;
        r = old;
        for (int i = 0; i < 4; i++) begin
            if (be[i]) begin
                r[8*i +: 8] = nw[8*i +: 8];
            end
        end
        return r;
    endfunction
    // pick one byte of a word by lane
    function automatic logic [7:0] pick(input word_t w, input logic [1:0] lane);
        return w[8*lane +: 8];
    endfunction
    // one wait cycle per access, answered on the second
    always_ff @(posedge i_sys_clk) begin
        if (i_srst) begin
            ack <= 1'b0;
        end else if (i_ce) begin
            ack <= (i_avs_read || i_avs_write) && !ack;
        end
    end
    assign o_avs_waitrequest = (i_avs_read || i_avs_write) && !ack;
    assign wr_hit            = i_avs_write && ack && i_ce;
    // register writes
    always_ff @(posedge i_sys_clk) begin
        if (i_srst) begin
            base_word_zero     <= `RST_WORD;
            base_word_one      <= `RST_WORD;
            prefix_low_group   <= `RST_WORD;
            prefix_high_group  <= `RST_WORD;
            tx_logical_select  <= `RST_WORD;
            rx_logical_enables <= `RST_WORD;
            crc_config         <= `RST_WORD;
            crc_polynomial     <= `RST_WORD;
            crc_seed           <= `RST_WORD;
            base_byte_count    <= {13'h0, `BASE_CNT_RESET, 16'h0};
        end else if (wr_hit) begin
            case (i_avs_address)
                `ADDR_BASE_WORD_ZERO: base_word_zero     <= merge(base_word_zero, i_avs_writedata, i_avs_byteenable);
                `ADDR_BASE_WORD_ONE:  base_word_one      <= merge(base_word_one, i_avs_writedata, i_avs_byteenable);
                `ADDR_PREFIX_LOW:     prefix_low_group   <= merge(prefix_low_group, i_avs_writedata, i_avs_byteenable);
                `ADDR_PREFIX_HIGH:    prefix_high_group  <= merge(prefix_high_group, i_avs_writedata, i_avs_byteenable);
                `ADDR_TX_SELECT:      tx_logical_select  <= merge(tx_logical_select, i_avs_writedata, i_avs_byteenable)
                                                          & 32'h0000_0007;
                `ADDR_RX_ENABLES:     rx_logical_enables <= merge(rx_logical_enables, i_avs_writedata, i_avs_byteenable)
                                                          & 32'h0000_00FF;
                `ADDR_CRC_CONFIG:     crc_config         <= merge(crc_config, i_avs_writedata, i_avs_byteenable)
                                                          & 32'h0000_0103;
                `ADDR_CRC_POLY:       crc_polynomial     <= merge(crc_polynomial, i_avs_writedata, i_avs_byteenable)
                                                          & 32'h00FF_FFFF;
                `ADDR_CRC_SEED:       crc_seed           <= merge(crc_seed, i_avs_writedata, i_avs_byteenable)
                                                          & 32'h00FF_FFFF;
                `ADDR_BASE_BYTE_COUNT: base_byte_count   <= merge(base_byte_count, i_avs_writedata, i_avs_byteenable)
                                                          & 32'h0007_0000;
                default: ;
            endcase
        end
    end
    // read data registered; unmapped reads zero
    always_ff @(posedge i_sys_clk) begin
        if (i_srst) begin
            o_avs_readdata <= '0;
        end else if (i_ce && i_avs_read && !ack) begin
            case (i_avs_address)
                `ADDR_BASE_WORD_ZERO:  o_avs_readdata <= base_word_zero;
                `ADDR_BASE_WORD_ONE:   o_avs_readdata <= base_word_one;
                `ADDR_PREFIX_LOW:      o_avs_readdata <= prefix_low_group;
                `ADDR_PREFIX_HIGH:     o_avs_readdata <= prefix_high_group;
                `ADDR_TX_SELECT:       o_avs_readdata <= tx_logical_select;
                `ADDR_RX_ENABLES:      o_avs_readdata <= rx_logical_enables;
                `ADDR_CRC_CONFIG:      o_avs_readdata <= crc_config;
                `ADDR_CRC_POLY:        o_avs_readdata <= crc_polynomial;
                `ADDR_CRC_SEED:        o_avs_readdata <= crc_seed;
                `ADDR_BASE_BYTE_COUNT: o_avs_readdata <= {base_byte_count[31:1], o_busy};
                default:               o_avs_readdata <= '0;
            endcase
        end
    end
    // ********************************************************************
    // address selection
    // ********************************************************************
    crc_len_t   crc_len;
    logic       skip_addr;
    lane_t      tx_sel;
    lane_t      base_len;
    word_t      tx_base;
    logic [7:0] tx_prefix;
    // configuration fields picked out of the register words
    assign crc_len   = crc_config[`CRC_LEN_MSB:`CRC_LEN_LSB];
    assign skip_addr = crc_config[`CRC_SKIP_BIT];
    assign tx_sel    = tx_logical_select[`TX_SEL_MSB:0];
    assign base_len  = base_byte_count[`BASE_CNT_MSB:`BASE_CNT_LSB];
    // reception allowed per logical address
    assign o_rx_allowed = rx_logical_enables[i_rx_logical];
    // base word and prefix byte for the transmit address
    always_comb begin
        tx_base   = (tx_sel == 3'h0) ? base_word_zero : base_word_one;
        tx_prefix = tx_sel[2] ? pick(prefix_high_group, tx_sel[1:0])
                              : pick(prefix_low_group, tx_sel[1:0]);
    end
    // ********************************************************************
    // frame serialiser
    // ********************************************************************
    frame_state_t state;
    lane_t        idx;
    logic [7:0]   cur_byte;
    logic         take;
    logic         crc_feed;
    logic [`CRC_WIDTH-1:0] crc_val;
    // address bytes: base msb-aligned bytes, then prefix last
    // idx counts base bytes from the top lane; the prefix goes out once it equals base_len
    always_comb begin
        if (idx == base_len) begin
            cur_byte = tx_prefix;
        end else begin
            cur_byte = pick(tx_base, 2'(3'h3 - idx));
        end
    end
    // the output register is empty or the sink takes its byte this cycle
    assign take         = i_ce && (!o_tx_valid || i_tx_ready);
    assign o_body_ready = (state == ST_BODY) && take;
    assign o_busy       = (state != ST_IDLE);
    // crc fed by address bytes unless skipped, then all body bytes
    assign crc_feed = (state == ST_ADDR && take && !skip_addr)
                    || (o_body_ready && i_body_valid);
    crc_engine u_crc (
        .i_sys_clk    (i_sys_clk),
        .i_srst       (i_srst),
        .i_ce         (i_ce),
        .i_start      (state == ST_IDLE && i_tx_start),
        .i_seed       (crc_seed[`CRC_WIDTH-1:0]),
        .i_poly       (crc_polynomial[`CRC_WIDTH-1:0]),
        .i_len        (crc_len),
        .i_byte_valid (crc_feed),
        .i_byte       ((state == ST_ADDR) ? cur_byte : i_body_byte),
        .o_crc        (crc_val)
    );
    // state sequence and output byte stream
    always_ff @(posedge i_sys_clk) begin
        if (i_srst) begin
            state      <= ST_IDLE;
            idx        <= '0;
            o_tx_valid <= 1'b0;
            o_tx_byte  <= '0;
            o_tx_last  <= 1'b0;
        end else if (take) begin
            o_tx_valid <= 1'b0;
            o_tx_last  <= 1'b0;
            case (state)
                ST_IDLE: begin
                    if (i_tx_start) begin
                        state <= ST_ADDR;
                        idx   <= 3'h0; // first base byte is the top lane
                    end
                end
                ST_ADDR: begin
                    // one address byte per accepted cycle
                    o_tx_valid <= 1'b1;
                    o_tx_byte  <= cur_byte;
                    if (idx == base_len) begin
                        state <= ST_BODY;
                    end else begin
                        idx <= idx + 3'h1;
                    end
                    if (idx == base_len && base_len == 3'h4) begin
                        state <= ST_BODY;
                    end
                end
                ST_BODY: begin
                    if (i_body_valid) begin
                        o_tx_valid <= 1'b1;
                        o_tx_byte  <= i_body_byte;
                        if (i_body_last) begin
                            if (crc_len == 2'h0) begin
                                o_tx_last <= 1'b1;
                                state     <= ST_DONE;
                            end else begin
                                state <= ST_CRC;
                                idx   <= 3'(crc_len);
                            end
                        end
                    end
                end
                ST_CRC: begin
                    // crc bytes leave msb first while idx counts down to one
                    o_tx_valid <= 1'b1;
                    o_tx_byte  <= crc_val[8*(idx-3'h1) +: 8];
                    idx        <= idx - 3'h1;
                    if (idx == 3'h1) begin
                        o_tx_last <= 1'b1;
                        state     <= ST_DONE;
                    end
                end
                ST_DONE: state <= ST_IDLE;
                default: state <= ST_IDLE;
            endcase
        end
    end
endmodule

/* File: bench/radio_sink_model.sv */
`timescale 1ns/100ps
// ****************************************
// air side sink: stalls at random, keeps every byte taken
// ****************************************
module radio_sink_model (
    input  wire logic       i_sys_clk,
    input  wire logic       i_srst,
    input  wire logic       i_valid,
    input  wire logic [7:0] i_byte,
    input  wire logic       i_last,
    output logic            o_ready
);
    logic [7:0] got[$];
    logic [3:0] lf = 4'h9;
    int         frames = 0;
    initial o_ready = 1'b0;
    // ready pattern changes every cycle; a byte counts on valid and ready
    always @(posedge i_sys_clk) begin
        lf <= i_srst ? 4'h9 : {lf[2:0], lf[3] ^ lf[2]};
        o_ready <= !i_srst && (lf[0] | lf[1]);
        if (!i_srst && i_valid && o_ready) begin
            got.push_back(i_byte);
            if (i_last) frames <= frames + 1;
        end
    end
endmodule

/* File: bench/radio_cfg_asserts.sv */
`timescale 1ns/100ps
// ****************************************
// port checks: bus answer timing and byte stream
// ****************************************
module radio_cfg_asserts (
    input wire logic        i_sys_clk,
    input wire logic        i_srst,
    input wire logic        i_ce,
    input wire logic        i_avs_read,
    input wire logic        i_avs_write,
    input wire logic [31:0] o_avs_readdata,
    input wire logic        o_avs_waitrequest,
    input wire logic        i_tx_start,
    input wire logic        i_tx_ready,
    input wire logic        o_body_ready,
    input wire logic        o_tx_valid,
    input wire logic [7:0]  o_tx_byte,
    input wire logic        o_tx_last,
    input wire logic        o_busy
);
    default clocking cb @(posedge i_sys_clk); endclocking
    default disable iff (i_srst);
    // access steps: request rises, one wait cycle, answer
    sequence s_req_rise; $rose(i_avs_read | i_avs_write) && i_ce; endsequence
    sequence s_one_wait; o_avs_waitrequest ##1 !o_avs_waitrequest; endsequence
    property p_one_wait; s_req_rise |-> s_one_wait; endproperty
    a_one_wait: assert property (p_one_wait) else $error("access wait not one cycle");
    property p_idle_bus; !(i_avs_read | i_avs_write) |-> !o_avs_waitrequest; endproperty
    a_idle_bus: assert property (p_idle_bus) else $error("wait without access");
    property p_rd_stand; !i_avs_read |=> $stable(o_avs_readdata); endproperty
    a_rd_stand: assert property (p_rd_stand) else $error("read data moved");
    // stream byte holds through a stall
    sequence s_stall; o_tx_valid && !i_tx_ready; endsequence
    property p_hold; s_stall |=> o_tx_valid && $stable(o_tx_byte) && $stable(o_tx_last); endproperty
    a_hold: assert property (p_hold) else $error("byte changed in stall");
    property p_last; o_tx_last |-> o_tx_valid; endproperty
    a_last: assert property (p_last) else $error("last without valid");
    property p_in_frame; o_tx_valid || o_body_ready |-> o_busy; endproperty
    a_in_frame: assert property (p_in_frame) else $error("stream outside frame");
    property p_start; i_tx_start && !o_busy && i_ce |=> o_busy; endproperty
    a_start: assert property (p_start) else $error("start not taken");
    property p_end; $rose(o_busy) |-> ##[1:400] !o_busy; endproperty
    a_end: assert property (p_end) else $error("frame never ends");
endmodule
bind radio_address_crc_config radio_cfg_asserts i_chk (.i_sys_clk(i_sys_clk), .i_srst(i_srst), .i_ce(i_ce),
    .i_avs_read(i_avs_read), .i_avs_write(i_avs_write), .o_avs_readdata(o_avs_readdata),
    .o_avs_waitrequest(o_avs_waitrequest), .i_tx_start(i_tx_start), .i_tx_ready(i_tx_ready),
    .o_body_ready(o_body_ready), .o_tx_valid(o_tx_valid), .o_tx_byte(o_tx_byte), .o_tx_last(o_tx_last),
    .o_busy(o_busy));

/* File: bench/tb.sv */
`timescale 1ns/100ps
`include "radio_cfg_regs.svh"
module tb;
    import radio_cfg_pkg::*;
    logic                   i_sys_clk = 1'b0;
    logic                   i_srst = 1'b1;
    logic                   i_ce = 1'b1;
    logic [`ADDR_WIDTH-1:0] i_avs_address = '0;
    logic                   i_avs_read = 1'b0;
    logic                   i_avs_write = 1'b0;
    logic [3:0]             i_avs_byteenable = 4'hF;
    word_t                  i_avs_writedata = '0;
    word_t                  o_avs_readdata;
    logic                   o_avs_waitrequest, i_tx_ready, o_body_ready, o_tx_valid, o_tx_last, o_rx_allowed, o_busy;
    logic                   i_tx_start = 1'b0;
    logic                   i_body_valid = 1'b0;
    logic [7:0]             i_body_byte = 8'h00;
    logic                   i_body_last = 1'b0;
    logic [7:0]             o_tx_byte;
    lane_t                  i_rx_logical = 3'h0;
    word_t                  seed = 32'h0001_356A;
    word_t                  q, wd;
    int                     n_fail = 0;
    int                     n_checks = 0;
    localparam logic [11:0] RA [9] = '{`ADDR_BASE_WORD_ZERO, `ADDR_BASE_WORD_ONE, `ADDR_PREFIX_LOW, `ADDR_PREFIX_HIGH,
        `ADDR_TX_SELECT, `ADDR_RX_ENABLES, `ADDR_CRC_CONFIG, `ADDR_CRC_POLY, `ADDR_CRC_SEED};
    localparam word_t       RM [9] = '{32'hFFFF_FFFF, 32'hFFFF_FFFF, 32'hFFFF_FFFF, 32'hFFFF_FFFF, 32'h0000_0007,
        32'h0000_00FF, 32'h0000_0103, 32'h00FF_FFFE, 32'h00FF_FFFF};
    radio_address_crc_config i_dut (.i_sys_clk(i_sys_clk), .i_srst(i_srst), .i_ce(i_ce),
        .i_avs_address(i_avs_address), .i_avs_read(i_avs_read), .i_avs_write(i_avs_write),
        .i_avs_byteenable(i_avs_byteenable), .i_avs_writedata(i_avs_writedata), .o_avs_readdata(o_avs_readdata),
        .o_avs_waitrequest(o_avs_waitrequest), .i_tx_start(i_tx_start), .i_tx_ready(i_tx_ready),
        .i_body_valid(i_body_valid), .i_body_byte(i_body_byte), .i_body_last(i_body_last),
        .o_body_ready(o_body_ready), .o_tx_valid(o_tx_valid), .o_tx_byte(o_tx_byte), .o_tx_last(o_tx_last),
        .i_rx_logical(i_rx_logical), .o_rx_allowed(o_rx_allowed), .o_busy(o_busy));
    radio_sink_model i_sink (.i_sys_clk(i_sys_clk), .i_srst(i_srst), .i_valid(o_tx_valid), .i_byte(o_tx_byte),
        .i_last(o_tx_last), .o_ready(i_tx_ready));
    // ****************************************
    // helpers
    // ****************************************
    function automatic word_t rnd();
        seed = {seed[30:0], seed[31] ^ seed[21] ^ seed[1] ^ seed[0]};
        return seed;
    endfunction
    // one byte through the crc, msb first
    function automatic word_t crc_byte(word_t c, logic [7:0] b, word_t p, int w);
        for (int j = 7; j >= 0; j--) c = (c << 1) ^ ((c[w - 1] ^ b[j]) ? p : '0);
        return c;
    endfunction
    task automatic check(input word_t seen, input word_t exp);
        n_checks++;
        if (seen !== exp) begin
            n_fail++;
            $display("ERROR at %0t: seen %h expected %h", $time, seen, exp);
        end
    endtask
    task automatic end_of_test();
        $display("checks %0d mismatches %0d", n_checks, n_fail);
        if (n_fail == 0 && n_checks > 0) $display("Simulation passed");
        else $display("Simulation failed");
        $finish;
    endtask
    // bus access held until waitrequest is sampled low
    task automatic bus(input logic w, input logic [11:0] a, input word_t d, input logic [3:0] b, output word_t r);
        @(posedge i_sys_clk);
        i_avs_address <= a;
        i_avs_write <= w;
        i_avs_read <= !w;
        i_avs_byteenable <= b;
        i_avs_writedata <= d;
        do begin
            @(posedge i_sys_clk);
        end while (o_avs_waitrequest !== 1'b0);
        r = o_avs_readdata;
        i_avs_read <= 1'b0;
        i_avs_write <= 1'b0;
    endtask
    // one frame with fresh random settings, stream compared to the model
    task automatic frame(input lane_t la, input crc_len_t len, input logic skip);
        word_t      cfg [9];
        word_t      crc, base, pre;
        logic [7:0] exp[$];
        int         i, bal, w, nb, f0, n;
        foreach (cfg[k]) cfg[k] = rnd();
        cfg[4] = {29'h0, la};
        cfg[6] = {23'h0, skip, 6'h00, len};
        for (i = 0; i < 9; i++) bus(1'b1, RA[i], cfg[i], 4'hF, q);
        bal = 1 + rnd() % 4;
        bus(1'b1, `ADDR_BASE_BYTE_COUNT, word_t'(bal) << 16, 4'hF, q);
        base = (la == 3'h0) ? cfg[0] : cfg[1];
        pre = la[2] ? cfg[3] : cfg[2];
        for (i = 0; i < bal; i++) exp.push_back(base[31 - 8 * i -: 8]);
        exp.push_back(pre[8 * la[1:0] +: 8]);
        w = 8 * len;
        crc = cfg[8];
        nb = 1 + rnd() % 4;
        for (i = 0; i < bal + 1 + nb; i++) begin
            if (i > bal) exp.push_back(8'(rnd()));
            if (len != 0 && (!skip || i > bal)) crc = crc_byte(crc, exp[i], cfg[7] | 32'h1, w);
        end
        for (i = 0; i < len; i++) exp.push_back(crc[w - 1 - 8 * i -: 8]);
        i_sink.got.delete();
        f0 = i_sink.frames;
        while (o_busy !== 1'b0) @(posedge i_sys_clk);
        i_tx_start <= 1'b1;
        @(posedge i_sys_clk);
        i_tx_start <= 1'b0;
        for (i = 0; i < nb; i++) begin
            i_body_valid <= 1'b1;
            i_body_byte <= exp[bal + 1 + i];
            i_body_last <= (i == nb - 1);
            n = 0;
            do begin
                @(posedge i_sys_clk);
                n++;
            end while (o_body_ready !== 1'b1 && n < 300);
        end
        i_body_valid <= 1'b0;
        n = 0;
        while (i_sink.frames == f0 && n < 300) begin
            @(posedge i_sys_clk);
            n++;
        end
        check(word_t'(i_sink.got.size()), word_t'(exp.size()));
        foreach (exp[k]) check({24'h0, i_sink.got[k]}, {24'h0, exp[k]});
    endtask
    // ****************************************
    // clock, watchdog and main sequence
    // ****************************************
    initial begin
        forever #2.5 i_sys_clk = ~i_sys_clk;
    end
    initial begin
        repeat (60000) @(posedge i_sys_clk);
        n_fail++;
        end_of_test();
    end
    initial begin
        repeat (10) @(posedge i_sys_clk);
        // reset values and random read back, twice with a reset between
        for (int r = 0; r < 2; r++) begin
            i_srst <= 1'b0;
            for (int i = 0; i < 9; i++) begin
                bus(1'b0, RA[i], '0, 4'hF, q);
                if (i < 2 || i > 4) check(q, '0);
            end
            bus(1'b0, `ADDR_BASE_BYTE_COUNT, '0, 4'hF, q);
            check(q, 32'h0004_0000);
            for (int i = 0; i < 9; i++) begin
                wd = rnd();
                bus(1'b1, RA[i], wd, 4'hF, q);
                bus(1'b0, RA[i], '0, 4'hF, q);
                check(i == 7 ? q & ~32'h1 : q, wd & RM[i]);
            end
            i_srst <= 1'b1;
            repeat (2) @(posedge i_sys_clk);
        end
        i_srst <= 1'b0;
        // byte lanes and an unmapped place
        bus(1'b1, `ADDR_BASE_WORD_ZERO, 32'hFFFF_FFFF, 4'hF, q);
        bus(1'b1, `ADDR_BASE_WORD_ZERO, 32'h0000_0000, 4'h2, q);
        bus(1'b0, `ADDR_BASE_WORD_ZERO, '0, 4'hF, q);
        check(q, 32'hFFFF_00FF);
        bus(1'b1, 12'h600, 32'hA5A5_A5A5, 4'hF, q);
        bus(1'b0, 12'h600, '0, 4'hF, q);
        check(q, '0);
        // per address receive enables
        for (int r = 0; r < 3; r++) begin
            wd = (r == 0) ? 32'h0000_0081 : rnd();
            bus(1'b1, `ADDR_RX_ENABLES, wd, 4'hF, q);
            for (int i = 0; i < 8; i++) begin
                i_rx_logical <= lane_t'(i);
                @(posedge i_sys_clk);
                @(posedge i_sys_clk);
                check({31'h0, o_rx_allowed}, {31'h0, wd[i]});
            end
        end
        for (int k = 0; k < 16; k++) frame(lane_t'(k), crc_len_t'(k), k >= 8);
        end_of_test();
    end
endmodule
